// File: core/opc_pkg.sv
// Operation
// - Invert word-clock/overrange pair when polarity set, LVDS.
// - Drive the pair only while enable bit set.
// - Any trigger-bit change starts PLL recalibration.
// - Calibration progress shown in separate status register.
// - Gating bit one routes PLL clock to core.
// - Delay field is a 3-bit code selecting whole VCO cycles, 0 to 15.
// - Gating and delay need PLL selected and enabled.
// - Output delay only without decimation active.
// - Pattern A is high byte plus low upper nibble.
// - Pattern B assembled the same way.
// - Selector code 001 alternates patterns A and B.
// - Pattern top bits map to overrange, word clock.
`default_nettype none
package opc_pkg;

	// ==========================================================
	// Bus and register geometry
	localparam int ADDR_W   = 10;
	localparam int DATA_W   = 32;
	localparam int BYTE_W   = 8;
	localparam int IDX_W    = ADDR_W - 2;
	localparam int NUM_REGS = 7;
	localparam int SLOT_W   = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PAIR     = 8'h68;
	localparam logic [IDX_W-1:0] IDX_CAL      = 8'h6b;
	localparam logic [IDX_W-1:0] IDX_GATE     = 8'h6d;
	localparam logic [IDX_W-1:0] IDX_PAT_A_LO = 8'h74;
	localparam logic [IDX_W-1:0] IDX_PAT_A_HI = 8'h75;
	localparam logic [IDX_W-1:0] IDX_PAT_B_LO = 8'h76;
	localparam logic [IDX_W-1:0] IDX_PAT_B_HI = 8'h77;
	localparam logic [IDX_W-1:0] IDX_CAL_STAT = 8'hd1;

	// ==========================================================
	// Storage slots
	localparam logic [SLOT_W-1:0] SLOT_PAIR = 3'h0;
	localparam logic [SLOT_W-1:0] SLOT_CAL  = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_GATE = 3'h2;

	localparam logic [IDX_W-1:0] SLOT_IDX [NUM_REGS] = '{
		IDX_PAIR, IDX_CAL, IDX_GATE, IDX_PAT_A_LO, IDX_PAT_A_HI, IDX_PAT_B_LO, IDX_PAT_B_HI
	};
	localparam logic [BYTE_W-1:0] SLOT_RST [NUM_REGS] = '{
		8'h24, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};
	localparam logic [BYTE_W-1:0] SLOT_WMASK [NUM_REGS] = '{
		8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff
	};
	localparam logic [SLOT_W-1:0] SLOT_PAT_LO [2] = '{3'h3, 3'h5};
	localparam logic [SLOT_W-1:0] SLOT_PAT_HI [2] = '{3'h4, 3'h6};

	// ==========================================================
	// Field positions
	localparam int PAIR_POL_BIT  = 3;
	localparam int PAIR_EN_BIT   = 2;
	localparam int CAL_TRIG_BIT  = 2;
	localparam int GATE_EN_BIT   = 5;
	localparam int DLY_LSB       = 1;
	localparam int DLY_W         = 3;
	localparam int DLY_CNT_W     = 4;
	localparam int PAT_NIB_LSB   = 4;
	localparam int PAT_W         = 12;
	localparam int PAT_OVR_BIT   = 11;
	localparam int PAT_WCK_BIT   = 10;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_GATE_BIT = 1;

	// Delay code to VCO cycle count.
	localparam logic [DLY_CNT_W-1:0] DLY_TABLE [8] = '{
		4'h0, 4'h1, 4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'hf
	};

	localparam logic [2:0] SEL_USER_PAIR = 3'h1;

endpackage
`default_nettype wire

// File: core/opc_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
module opc_axil_slave
	import opc_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// Write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// Read address and data
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [DATA_W-1:0]      rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Register side
	output logic                   wr_en,
	output logic [IDX_W-1:0]       wr_idx,
	output logic [BYTE_W-1:0]      wr_data,
	input  wire logic              wr_hit,
	output logic [IDX_W-1:0]       rd_idx,
	input  wire logic [BYTE_W-1:0] rd_data,
	input  wire logic              rd_hit
);

	// ==========================================================
	// Write path
	logic              aw_held_r, aw_held_nxt;
	logic              w_held_r, w_held_nxt;
	logic [IDX_W-1:0]  widx_r, widx_nxt;
	logic [BYTE_W-1:0] wbyte_r, wbyte_nxt;
	logic              wlane_r, wlane_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              do_wr;

	assign awready = !aw_held_r && !bvalid_r;
	assign wready  = !w_held_r && !bvalid_r;
	assign do_wr   = aw_held_r && w_held_r && !bvalid_r;
	assign wr_en   = do_wr && wlane_r;
	assign wr_idx  = widx_r;
	assign wr_data = wbyte_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;

	always_comb
	begin
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		widx_nxt    = widx_r;
		wbyte_nxt   = wbyte_r;
		wlane_nxt   = wlane_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (awvalid && awready)
		begin
			aw_held_nxt = 1'b1;
			widx_nxt    = awaddr[ADDR_W-1:2];
		end
		if (wvalid && wready)
		begin
			w_held_nxt = 1'b1;
			wbyte_nxt  = wdata[BYTE_W-1:0];
			wlane_nxt  = wstrb[0];
		end
		if (do_wr)
		begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_r && bready)
			bvalid_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			widx_r    <= '0;
			wbyte_r   <= '0;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			widx_r    <= widx_nxt;
			wbyte_r   <= wbyte_nxt;
			wlane_r   <= wlane_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
		end
	end

	// ==========================================================
	// Read path
	logic              rvalid_r, rvalid_nxt;
	logic [BYTE_W-1:0] rbyte_r, rbyte_nxt;
	logic [1:0]        rresp_r, rresp_nxt;

	assign arready = !rvalid_r;
	assign rd_idx  = araddr[ADDR_W-1:2];
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = {{(DATA_W-BYTE_W){1'b0}}, rbyte_r};

	always_comb
	begin
		rvalid_nxt = rvalid_r;
		rbyte_nxt  = rbyte_r;
		rresp_nxt  = rresp_r;
		if (arvalid && arready)
		begin
			rvalid_nxt = 1'b1;
			rbyte_nxt  = rd_data;
			rresp_nxt  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && rready)
			rvalid_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rbyte_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end
		else
		begin
			rvalid_r <= rvalid_nxt;
			rbyte_r  <= rbyte_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

endmodule
`default_nettype wire

// File: core/opc_pattern_out.sv
`timescale 1ns/100ps
`default_nettype none
module opc_pattern_out
	import opc_pkg::*;
(
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Settings
	input  wire logic [PAT_W-1:0] pattern_a,
	input  wire logic [PAT_W-1:0] pattern_b,
	input  wire logic [2:0]       test_pattern_sel,
	input  wire logic             pair_polarity_invert,
	input  wire logic             pair_output_enable,
	input  wire logic             lvds_mode,
	// Data path timing and normal pair sources
	input  wire logic             word_strobe,
	input  wire logic             word_clk_in,
	input  wire logic             overrange_in,
	// Outputs
	output logic [PAT_W-1:0]      pattern_data,
	output logic                  pattern_active,
	output logic                  word_clock_output,
	output logic                  overrange_output,
	output logic                  pair_oe_n
);

	// ==========================================================
	// Pattern alternation and pair drive
	logic             use_b_r, use_b_nxt;
	logic [PAT_W-1:0] data_r, data_nxt;
	logic             act_r, act_nxt;
	logic             wck_r, wck_nxt;
	logic             ovr_r, ovr_nxt;
	logic             oe_n_r, oe_n_nxt;
	logic             inv;

	always_comb
	begin
		act_nxt   = (test_pattern_sel == SEL_USER_PAIR);
		use_b_nxt = use_b_r;
		data_nxt  = data_r;
		if (!act_nxt)
		begin
			use_b_nxt = 1'b0;
			data_nxt  = '0;
		end
		else if (word_strobe)
		begin
			use_b_nxt = !use_b_r;
			data_nxt  = use_b_r ? pattern_b : pattern_a;
		end
		inv      = pair_polarity_invert && lvds_mode;
		wck_nxt  = 1'b0;
		ovr_nxt  = 1'b0;
		oe_n_nxt = !pair_output_enable;
		if (pair_output_enable)
		begin
			wck_nxt = (act_nxt ? data_nxt[PAT_WCK_BIT] : word_clk_in) ^ inv;
			ovr_nxt = (act_nxt ? data_nxt[PAT_OVR_BIT] : overrange_in) ^ inv;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			use_b_r <= 1'b0;
			data_r  <= '0;
			act_r   <= 1'b0;
			wck_r   <= 1'b0;
			ovr_r   <= 1'b0;
			oe_n_r  <= 1'b1;
		end
		else
		begin
			use_b_r <= use_b_nxt;
			data_r  <= data_nxt;
			act_r   <= act_nxt;
			wck_r   <= wck_nxt;
			ovr_r   <= ovr_nxt;
			oe_n_r  <= oe_n_nxt;
		end
	end

	assign pattern_data      = data_r;
	assign pattern_active    = act_r;
	assign word_clock_output = wck_r;
	assign overrange_output  = ovr_r;
	assign pair_oe_n         = oe_n_r;

endmodule
`default_nettype wire

// File: core/opc_regs.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module opc_regs
	import opc_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [DATA_W-1:0]      rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Clock system state
	input  wire logic              pll_selected,
	input  wire logic              pll_enabled,
	input  wire logic              decim_active,
	input  wire logic              pll_cal_busy,
	// Output data path state
	input  wire logic              lvds_mode,
	input  wire logic [2:0]        test_pattern_sel,
	input  wire logic              word_strobe,
	input  wire logic              word_clk_in,
	input  wire logic              overrange_in,
	// PLL controls
	output logic                   pll_cal_start,
	output logic                   pll_core_clk_en,
	output logic [DLY_CNT_W-1:0]   out_clock_vco_delay,
	// Pattern and pair outputs
	output logic [PAT_W-1:0]       pattern_data,
	output logic                   pattern_active,
	output logic                   word_clock_output,
	output logic                   overrange_output,
	output logic                   pair_oe_n
);

	// ==========================================================
	// Address decode
	// Returns the hit flag above the slot number of a stored register.
	function automatic logic [SLOT_W:0] find_slot(input logic [IDX_W-1:0] idx);
		logic [SLOT_W:0] res;
		res = '0;
		for (int i = 0; i < NUM_REGS; i++)
			if (SLOT_IDX[i] == idx)
				res = {1'b1, SLOT_W'(i)};
		return res;
	endfunction

	// ==========================================================
	// Bus front end
	logic              wr_en;
	logic [IDX_W-1:0]  wr_idx;
	logic [BYTE_W-1:0] wr_data;
	logic              wr_hit;
	logic [IDX_W-1:0]  rd_idx;
	logic [BYTE_W-1:0] rd_data;
	logic              rd_hit;
	logic [SLOT_W:0]   wr_dec;
	logic [SLOT_W:0]   rd_dec;

	opc_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.wr_hit  (wr_hit),
		.rd_idx  (rd_idx),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	assign wr_dec = find_slot(wr_idx);
	assign rd_dec = find_slot(rd_idx);
	assign wr_hit = wr_dec[SLOT_W] || (wr_idx == IDX_CAL_STAT);
	assign rd_hit = rd_dec[SLOT_W] || (rd_idx == IDX_CAL_STAT);

	// ==========================================================
	// Register storage and derived controls
	logic [BYTE_W-1:0]    reg_r [NUM_REGS];
	logic [BYTE_W-1:0]    reg_nxt [NUM_REGS];
	logic                 cal_start_r, cal_start_nxt;
	logic                 clk_en_r, clk_en_nxt;
	logic [DLY_CNT_W-1:0] dly_r, dly_nxt;
	logic                 pll_in_use;
	logic                 gate_eff;
	logic [BYTE_W-1:0]    stat_byte;

	assign pll_in_use = pll_selected && pll_enabled;
	assign gate_eff   = reg_r[SLOT_GATE][GATE_EN_BIT] && pll_in_use;

	always_comb
	begin
		for (int i = 0; i < NUM_REGS; i++)
		begin
			reg_nxt[i] = reg_r[i];
			// Written bits pass through SLOT_WMASK; gate register bits 7..6 always store zero.
			if (wr_en && wr_dec[SLOT_W] && (wr_dec[SLOT_W-1:0] == SLOT_W'(i)))
				reg_nxt[i] = wr_data & SLOT_WMASK[i];
		end
		cal_start_nxt = wr_en && wr_dec[SLOT_W] && (wr_dec[SLOT_W-1:0] == SLOT_CAL)
			&& (wr_data[CAL_TRIG_BIT] != reg_r[SLOT_CAL][CAL_TRIG_BIT]);
		clk_en_nxt = gate_eff;
		dly_nxt    = '0;
		if (pll_in_use && !decim_active)
			dly_nxt = DLY_TABLE[reg_r[SLOT_GATE][DLY_LSB +: DLY_W]];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				reg_r[i] <= SLOT_RST[i];
			cal_start_r <= 1'b0;
			clk_en_r    <= 1'b0;
			dly_r       <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_REGS; i++)
				reg_r[i] <= reg_nxt[i];
			cal_start_r <= cal_start_nxt;
			clk_en_r    <= clk_en_nxt;
			dly_r       <= dly_nxt;
		end
	end

	assign pll_cal_start       = cal_start_r;
	assign pll_core_clk_en     = clk_en_r;
	assign out_clock_vco_delay = dly_r;

	// ==========================================================
	// Read data
	always_comb
	begin
		stat_byte                = '0;
		stat_byte[STAT_BUSY_BIT] = pll_cal_busy;
		stat_byte[STAT_GATE_BIT] = clk_en_r;
		if (rd_idx == IDX_CAL_STAT)
			rd_data = stat_byte;
		else if (rd_dec[SLOT_W])
			rd_data = reg_r[rd_dec[SLOT_W-1:0]];
		else
			rd_data = '0;
	end

	// ==========================================================
	// User patterns
	logic [PAT_W-1:0] pattern [2];

	for (genvar g = 0; g < 2; g++)
	begin : g_pat
		// Upper nibble of the low register gives bits 3..0.
		assign pattern[g] = {reg_r[SLOT_PAT_HI[g]],
			reg_r[SLOT_PAT_LO[g]][BYTE_W-1:PAT_NIB_LSB]};
	end

	opc_pattern_out u_pat (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.pattern_a            (pattern[0]),
		.pattern_b            (pattern[1]),
		.test_pattern_sel     (test_pattern_sel),
		.pair_polarity_invert (reg_r[SLOT_PAIR][PAIR_POL_BIT]),
		.pair_output_enable   (reg_r[SLOT_PAIR][PAIR_EN_BIT]),
		.lvds_mode            (lvds_mode),
		.word_strobe          (word_strobe),
		.word_clk_in          (word_clk_in),
		.overrange_in         (overrange_in),
		.pattern_data         (pattern_data),
		.pattern_active       (pattern_active),
		.word_clock_output    (word_clock_output),
		.overrange_output     (overrange_output),
		.pair_oe_n            (pair_oe_n)
	);

endmodule
`default_nettype wire

// File: verif/opc_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module opc_regs_chk
	import opc_pkg::*;
(
	// Clock and reset
	input wire logic                 aclk,
	input wire logic                 aresetn,
	// Bus handshakes
	input wire logic                 awvalid,
	input wire logic                 awready,
	input wire logic                 wvalid,
	input wire logic                 wready,
	input wire logic                 bvalid,
	input wire logic                 arvalid,
	input wire logic                 arready,
	input wire logic                 rvalid,
	// Clock system and data path
	input wire logic                 pll_selected,
	input wire logic                 pll_enabled,
	input wire logic                 decim_active,
	input wire logic [2:0]           test_pattern_sel,
	input wire logic                 pll_cal_start,
	input wire logic                 pll_core_clk_en,
	input wire logic [DLY_CNT_W-1:0] out_clock_vco_delay,
	input wire logic [PAT_W-1:0]     pattern_data,
	input wire logic                 pattern_active,
	input wire logic                 word_clock_output,
	input wire logic                 overrange_output,
	input wire logic                 pair_oe_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Write sequence steps
	sequence both_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence store_then_resp;
		!bvalid ##1 bvalid;
	endsequence

	chk_write_resp: assert property (both_taken |=> store_then_resp)
		else $error("write response not after the store cycle");
	chk_read_resp: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read response late");
	chk_cal_single: assert property (pll_cal_start |=> !pll_cal_start)
		else $error("calibration start longer than one cycle");
	chk_cal_at_resp: assert property (pll_cal_start |-> $rose(bvalid))
		else $error("calibration start without a write");
	chk_gate_cond: assert property (pll_core_clk_en
		|-> $past(pll_selected) && $past(pll_enabled))
		else $error("core clock gated on without the PLL");
	chk_dly_cond: assert property (out_clock_vco_delay != 4'h0
		|-> $past(pll_selected) && $past(pll_enabled) && !$past(decim_active))
		else $error("output clock delay applied when not allowed");
	chk_pair_off: assert property (pair_oe_n |-> !word_clock_output && !overrange_output)
		else $error("pair driven while disabled");
	chk_pat_follow: assert property ($past(aresetn)
		|-> pattern_active == ($past(test_pattern_sel) == SEL_USER_PAIR))
		else $error("pattern activity does not follow selector");
	chk_pat_idle: assert property (!pattern_active |-> pattern_data == 12'h000)
		else $error("pattern data while inactive");
endmodule

bind opc_regs opc_regs_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
	.bvalid, .arvalid, .arready, .rvalid, .pll_selected, .pll_enabled, .decim_active,
	.test_pattern_sel, .pll_cal_start, .pll_core_clk_en, .out_clock_vco_delay,
	.pattern_data, .pattern_active, .word_clock_output, .overrange_output, .pair_oe_n);
`default_nettype wire

// File: verif/output_pll_pattern_control_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module output_pll_pattern_control_regs_tb
	import opc_pkg::*;
;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, pll_selected, pll_enabled;
	logic              decim_active, pll_cal_busy, lvds_mode, word_strobe, word_clk_in;
	logic              overrange_in, pll_cal_start, pll_core_clk_en, pattern_active;
	logic              word_clock_output, overrange_output, pair_oe_n, inv;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [3:0]        wstrb, out_clock_vco_delay;
	logic [1:0]        bresp, rresp;
	logic [2:0]        test_pattern_sel;
	logic [PAT_W-1:0]  pattern_data, pa, pb, ep;
	logic [7:0]        m [int];
	int                errors, n_compared, pulses, exp_pulses, k, j;

	opc_regs uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .pll_selected, .pll_enabled, .decim_active, .pll_cal_busy,
		.lvds_mode, .test_pattern_sel, .word_strobe, .word_clk_in, .overrange_in,
		.pll_cal_start, .pll_core_clk_en, .out_clock_vco_delay, .pattern_data,
		.pattern_active, .word_clock_output, .overrange_output, .pair_oe_n);

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	always @(posedge aclk)
		if (pll_cal_start === 1'b1)
			pulses++;

	// ==========================================================
	// Shared tasks
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [1:0] resp_of(input logic [7:0] idx);
		return (m.exists(idx) || idx == IDX_CAL_STAT) ? RESP_OKAY : RESP_SLVERR;
	endfunction

	function automatic logic [3:0] vco(input logic [2:0] c);
		return c == 3'h7 ? 4'hf : c < 3'h2 ? {1'b0, c} : {c, 1'b0} + 4'h2;
	endfunction

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (n > 60)
			begin
				errors++;
				final_report();
			end
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		chk(bresp, resp_of(idx));
		if (idx == IDX_CAL && m[idx][CAL_TRIG_BIT] != d[CAL_TRIG_BIT])
			exp_pulses++;
		if (m.exists(idx))
			m[idx] = (idx == IDX_GATE) ? d & 8'h3f : d;
	endtask

	task automatic rd(input logic [7:0] idx);
		int n;
		logic [31:0] ed;
		@(posedge aclk);
		ed = m.exists(idx) ? {24'h0, m[idx]} : 32'h0;
		if (idx == IDX_CAL_STAT)
			ed = {30'h0, m[IDX_GATE][GATE_EN_BIT] & pll_selected & pll_enabled, pll_cal_busy};
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (n > 60)
			begin
				errors++;
				final_report();
			end
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		chk(rdata, ed);
		chk(rresp, resp_of(idx));
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, arvalid, pll_selected, pll_enabled, decim_active} = 7'h0;
		{pll_cal_busy, lvds_mode, word_strobe, word_clk_in, overrange_in} = 5'h0;
		{bready, rready, wstrb, awaddr, araddr, wdata, test_pattern_sel} = '0;
		bready = 1'b1;
		rready = 1'b1;
		wstrb = 4'h1;
		for (k = 0; k < NUM_REGS; k++)
			m[SLOT_IDX[k]] = 8'h00;
		m[IDX_PAIR] = 8'h24;
		m[IDX_CAL] = 8'h08;
		void'($urandom(40048));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (m[i])
			rd(8'(i));
		rd(IDX_CAL_STAT);
		$display("test reset done");
		for (k = 0; k < 5; k++)
		begin
			pa = PAT_W'($urandom);
			pb = PAT_W'($urandom);
			wr(IDX_PAT_A_LO, {pa[3:0], 4'h0});
			wr(IDX_PAT_A_HI, pa[11:4]);
			wr(IDX_PAT_B_LO, {pb[3:0], 4'h0});
			wr(IDX_PAT_B_HI, pb[11:4]);
			wr(IDX_PAIR, {4'h2, k[0], k != 4, 2'h0});
			@(posedge aclk);
			lvds_mode <= k[1];
			word_clk_in <= 1'($urandom);
			overrange_in <= 1'($urandom);
			test_pattern_sel <= SEL_USER_PAIR;
			word_strobe <= 1'b1;
			inv = k[0] & k[1];
			for (j = 0; j < 4; j++)
			begin
				@(posedge aclk);
				#1;
				ep = j[0] ? pb : pa;
				chk({pattern_active, pattern_data}, {1'b1, ep});
				chk({pair_oe_n, overrange_output, word_clock_output},
					k != 4 ? {1'b0, ep[11] ^ inv, ep[10] ^ inv} : 3'h4);
			end
			@(posedge aclk);
			test_pattern_sel <= 3'h2 + 3'($urandom % 6);
			word_strobe <= 1'b0;
			repeat (2) @(posedge aclk);
			#1;
			chk({pattern_active, pattern_data, pair_oe_n, overrange_output, word_clock_output},
				{13'h0, k != 4 ? {1'b0, overrange_in ^ inv, word_clk_in ^ inv} : 3'h4});
		end
		$display("test pattern done");
		for (k = 0; k < 64; k++)
		begin
			wr(IDX_GATE, {2'h0, 1'($urandom), 1'b0, k[5:3], 1'b0});
			@(posedge aclk);
			pll_selected <= k[0];
			pll_enabled <= k[1];
			decim_active <= k[2];
			pll_cal_busy <= 1'($urandom);
			repeat (2) @(posedge aclk);
			#1;
			chk(pll_core_clk_en, m[IDX_GATE][GATE_EN_BIT] & k[0] & k[1]);
			chk(out_clock_vco_delay, k[1:0] == 2'h3 && !k[2] ? vco(k[5:3]) : 4'h0);
			rd(IDX_CAL_STAT);
		end
		$display("test clock done");
		for (k = 0; k < 10; k++)
		begin
			wr(IDX_CAL, {5'h01, k < 2 ? 1'b0 : 1'($urandom), 2'h0});
			repeat (2) @(posedge aclk);
			chk(pulses, exp_pulses);
		end
		wr(IDX_CAL_STAT, 8'hff);
		wr(8'h69, 8'h5a);
		foreach (m[i])
			rd(8'(i));
		rd(8'h69);
		$display("test calibration done");
		final_report();
	end
endmodule
`default_nettype wire
